// >>> rx_extract_map.vh
`ifndef RX_EXTRACT_MAP_VH
`define RX_EXTRACT_MAP_VH

// ----------------------------------------
// Register offsets within one channel.
// ----------------------------------------
`define MAP_IRQ_STATUS_OFS 12'h70b
`define MAP_IRQ_ENABLE_OFS 12'h70f
`define MAP_MEM_CTRL_OFS 12'h713

// ----------------------------------------
// Memory control field positions.
// ----------------------------------------
`define MAP_MC_EXT_RESET_N_BIT 4
`define MAP_MC_EXT_AVAIL_BIT 3
`define MAP_MC_INS_RESET_N_BIT 2
`define MAP_MC_INS_ROOM_BIT 1
`define MAP_MC_INS_SOC_BIT 0

// ----------------------------------------
// Interrupt enable and status field positions.
// ----------------------------------------
`define MAP_IRQ_EXTRACT_BIT 5
`define MAP_IRQ_USED_MSB 5

// ----------------------------------------
// Reset values.
// ----------------------------------------
`define MAP_MC_EXT_RESET_N_RST 1'b1
`define MAP_MC_INS_RESET_N_RST 1'b1
`define MAP_MC_INS_ROOM_RST 1'b1
`define MAP_MC_INS_SOC_RST 1'b0
`define MAP_IRQ_ENABLE_RST 6'h20
`define MAP_IRQ_STATUS_RST 8'h00

`endif

// >>> cell_occupancy.v
`timescale 1ns/1ps
`default_nettype none

module cell_occupancy #(
  parameter DEPTH_CELLS = 4,
  parameter CNT_W = 3
) (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire hold_reset,
  input wire cell_loaded,
  input wire cell_taken,
  output reg [CNT_W-1:0] count_q,
  output wire full
);

  // ----------------------------------------
  // Count of complete cells waiting to be read.
  // ----------------------------------------
  localparam [CNT_W-1:0] LAST = DEPTH_CELLS[CNT_W-1:0];

  wire do_inc;
  wire do_dec;

  assign full = (count_q == LAST);
  assign do_inc = cell_loaded & ~full;
  assign do_dec = cell_taken & (count_q != {CNT_W{1'b0}});

  always @(posedge clk) begin
    if (srst) begin
      count_q <= {CNT_W{1'b0}};
    end else if (ce) begin
      if (hold_reset) begin
        count_q <= {CNT_W{1'b0}}; // [RULE_02]
      end else if (do_inc & ~do_dec) begin
        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE_04]
      end else if (do_dec & ~do_inc) begin
        count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE_04]
      end
    end
  end

endmodule

`default_nettype wire

// >>> sticky_flag.v
`timescale 1ns/1ps
`default_nettype none

module sticky_flag (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire set,
  input wire clear,
  output reg flag_q
);

  // ----------------------------------------
  // Set beats clear in the same cycle.
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        flag_q <= 1'b1; // [RULE_10]
      end else if (clear) begin
        flag_q <= 1'b0; // [RULE_13]
      end
    end
  end

endmodule

`default_nettype wire

// >>> rx_cell_extract_buffer_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "rx_extract_map.vh"

// How it works
// [RULE_01] Software starts a flush by writing zero to extraction reset bit 4.
// [RULE_02] Writing bit 4 back to one completes the flush and empties the buffer.
// [RULE_03] Software should flush once after power-up before any cell traffic.
// [RULE_04] After first cell read, the buffer stays consistent without further flushes.
// [RULE_05] Cell-available bit 3 reads one while a complete cell waits.
// [RULE_06] Cell-available bit 3 reads zero while no cell waits.
// [RULE_07] Polling software waits for bit 3 before reading cell words.
// [RULE_08] With enable set, every loaded cell raises an interrupt; here cells loaded while bit 4 is low raise none.
// [RULE_09] Interrupt enable bit 5 gates cell-extraction interrupts.
// [RULE_10] A copied cell sets status bit 5 and drives the interrupt pin low.
// [RULE_11] Memory control: bits 7-5 unused, 4 ext reset, 3 avail, 2-0 insertion.
// [RULE_12] Interrupt enable: bits 7-6 unused, bits 5-0 read/write enables.
// [RULE_13] Interrupt pin returns high once no enabled status bit remains set.
module rx_cell_extract_buffer_ctrl #(
  parameter DEPTH_CELLS = 4,
  parameter CNT_W = 3
) (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire [11:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] wdata,
  output reg [7:0] rdata_q,
  input wire cell_loaded,
  input wire cell_taken,
  output reg ext_mem_reset_q,
  output reg ins_mem_reset_q,
  output reg cell_avail_q,
  output reg int_n_q
);

  // ----------------------------------------
  // Register state.
  // ----------------------------------------
  reg ext_reset_n_q;
  reg ins_reset_n_q;
  reg ins_room_q;
  reg ins_soc_q;
  reg [5:0] irq_enable_q;

  wire [CNT_W-1:0] cell_count;
  wire extract_status;
  wire sel_mc;
  wire sel_ie;
  wire sel_is;
  wire status_read;
  wire avail_now;
  wire [7:0] mc_value;
  wire [7:0] ie_value;
  wire [7:0] is_value;

  assign sel_mc = (addr == `MAP_MEM_CTRL_OFS);
  assign sel_ie = (addr == `MAP_IRQ_ENABLE_OFS);
  assign sel_is = (addr == `MAP_IRQ_STATUS_OFS);
  assign status_read = rd_en & sel_is;
  assign avail_now = (cell_count != {CNT_W{1'b0}});

  // ----------------------------------------
  // Control register writes.
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      ext_reset_n_q <= `MAP_MC_EXT_RESET_N_RST;
      ins_reset_n_q <= `MAP_MC_INS_RESET_N_RST;
      ins_room_q <= `MAP_MC_INS_ROOM_RST;
      ins_soc_q <= `MAP_MC_INS_SOC_RST;
      irq_enable_q <= `MAP_IRQ_ENABLE_RST;
    end else if (ce) begin
      if (wr_en & sel_mc) begin
        ext_reset_n_q <= wdata[`MAP_MC_EXT_RESET_N_BIT]; // [RULE_01] [RULE_11]
        ins_reset_n_q <= wdata[`MAP_MC_INS_RESET_N_BIT]; // [RULE_11]
        ins_room_q <= wdata[`MAP_MC_INS_ROOM_BIT]; // [RULE_11]
        ins_soc_q <= wdata[`MAP_MC_INS_SOC_BIT]; // [RULE_11]
      end
      if (wr_en & sel_ie) begin
        irq_enable_q <= wdata[`MAP_IRQ_USED_MSB:0]; // [RULE_12]
      end
    end
  end

  // ----------------------------------------
  // Cell count, held empty while the reset bit is low.
  // ----------------------------------------
  cell_occupancy #(
    .DEPTH_CELLS(DEPTH_CELLS),
    .CNT_W(CNT_W)
  ) u_occupancy (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .hold_reset(~ext_reset_n_q),
    .cell_loaded(cell_loaded),
    .cell_taken(cell_taken),
    .count_q(cell_count),
    .full()
  );

  // ----------------------------------------
  // Cell extraction status, cleared by reading it.
  // ----------------------------------------
  sticky_flag u_extract_status (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .set(cell_loaded & ext_reset_n_q),
    .clear(status_read),
    .flag_q(extract_status)
  );

  // ----------------------------------------
  // Read data.
  // ----------------------------------------
  assign mc_value = {3'b000, ext_reset_n_q, cell_avail_q, ins_reset_n_q, ins_room_q, ins_soc_q}; // [RULE_11]
  assign ie_value = {2'b00, irq_enable_q}; // [RULE_12]
  assign is_value = {2'b00, extract_status, 5'b00000};

  always @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      if (rd_en) begin
        if (sel_mc) begin
          rdata_q <= mc_value;
        end else if (sel_ie) begin
          rdata_q <= ie_value;
        end else if (sel_is) begin
          rdata_q <= is_value;
        end else begin
          rdata_q <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs.
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      ext_mem_reset_q <= 1'b0;
      ins_mem_reset_q <= 1'b0;
      cell_avail_q <= 1'b0;
      int_n_q <= 1'b1;
    end else if (ce) begin
      ext_mem_reset_q <= ~ext_reset_n_q; // [RULE_02]
      ins_mem_reset_q <= ~ins_reset_n_q;
      cell_avail_q <= avail_now & ext_reset_n_q; // [RULE_05] [RULE_06]
      int_n_q <= ~(extract_status & irq_enable_q[`MAP_IRQ_EXTRACT_BIT]); // [RULE_08] [RULE_09] [RULE_13]
    end
  end

endmodule

`default_nettype wire

// >>> extract_chk.sv
`timescale 1ns/1ps
`default_nettype none
module extract_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [11:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata_q,
  input wire logic cell_loaded,
  input wire logic cell_taken,
  input wire logic ext_mem_reset_q,
  input wire logic cell_avail_q,
  input wire logic int_n_q
);
  logic en_q;
  always @(posedge clk) begin
    if (srst) en_q <= 1'b1;
    else if (ce && wr_en && addr == 12'h70f) en_q <= wdata[5];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_avail_cause: assert property ($rose(cell_avail_q) |-> $past(cell_loaded, 2)) else $error("avail");
  a_avail_clear: assert property ($fell(cell_avail_q) && !$past(srst) |-> $past(cell_taken, 2) || ext_mem_reset_q) else $error("clr");
  a_irq_raise: assert property (ce && cell_loaded && en_q && !ext_mem_reset_q |-> ##2 !int_n_q) else $error("irq");
  a_irq_cause: assert property ($fell(int_n_q) |-> $past(cell_loaded, 2) || !$past(en_q, 2)) else $error("pin");
  a_irq_mask: assert property (!en_q |=> int_n_q) else $error("mask");
  a_irq_release: assert property (rd_en && addr == 12'h70b && !cell_loaded |=> ##1 int_n_q) else $error("rel");
  a_ctrl_read: assert property (rd_en && addr == 12'h713 |=>
    rdata_q[7:5] == 3'h0 && rdata_q[3] == $past(cell_avail_q)) else $error("ctrl");
  a_en_read: assert property (rd_en && addr == 12'h70f |=> rdata_q[7:5] == {2'h0, $past(en_q)}) else $error("en");
  c_cell_irq: cover property (cell_loaded ##2 !int_n_q);
  c_flush: cover property ($fell(ext_mem_reset_q));
  c_masked: cover property (!en_q && cell_loaded);
endmodule
bind rx_cell_extract_buffer_ctrl extract_chk u_chk (
  .clk(clk),
  .srst(srst),
  .ce(ce),
  .addr(addr),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .wdata(wdata),
  .rdata_q(rdata_q),
  .cell_loaded(cell_loaded),
  .cell_taken(cell_taken),
  .ext_mem_reset_q(ext_mem_reset_q),
  .cell_avail_q(cell_avail_q),
  .int_n_q(int_n_q)
);
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, srst, wr_en, rd_en, cell_loaded, cell_taken;
  logic ce;
  logic [11:0] addr;
  logic [7:0] wdata;
  wire [7:0] rdata_q;
  wire ext_mem_reset_q, ins_mem_reset_q, cell_avail_q, int_n_q;
  int n_errors = 0;
  int n_checks = 0;
  typedef struct {logic [11:0] a; logic w; logic [7:0] d, e;} row_t;
  row_t rows [7] = '{'{12'h713, 0, 8'h00, 8'h16}, '{12'h70f, 0, 8'h00, 8'h20}, '{12'h70b, 0, 8'h00, 8'h00},
    '{12'h700, 1, 8'hff, 8'h00}, '{12'h70f, 1, 8'hff, 8'h3f}, '{12'h713, 1, 8'hff, 8'h17},
    '{12'h713, 1, 8'h00, 8'h00}};
  rx_cell_extract_buffer_ctrl dut (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .addr(addr),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .wdata(wdata),
    .rdata_q(rdata_q),
    .cell_loaded(cell_loaded),
    .cell_taken(cell_taken),
    .ext_mem_reset_q(ext_mem_reset_q),
    .ins_mem_reset_q(ins_mem_reset_q),
    .cell_avail_q(cell_avail_q),
    .int_n_q(int_n_q)
  );
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ck(logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  task automatic acc(logic [11:0] a, logic w, logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = w;
    rd_en = !w;
    tick();
    wr_en = 1'b0;
    rd_en = 1'b0;
    tick();
  endtask
  task automatic pulse(logic l, t);
    cell_loaded = l;
    cell_taken = t;
    tick();
    cell_loaded = 1'b0;
    cell_taken = 1'b0;
    tick();
  endtask
  task automatic summarize;
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #20000;
    n_errors++;
    summarize;
  end
  initial begin
    {wr_en, rd_en, cell_loaded, cell_taken, addr, wdata} = '0;
    ce = 1'b1;
    srst = 1'b1;
    tick(5);
    srst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) acc(rows[i].a, 1, rows[i].d);
      acc(rows[i].a, 0, 0);
      ck(rdata_q, rows[i].e);
    end
    ck(ext_mem_reset_q, 1);
    pulse(1, 0);
    acc(12'h713, 1, 8'h10);
    ck(ins_mem_reset_q, 1);
    ck(cell_avail_q, 0);
    ck(int_n_q, 1);
    pulse(1, 0);
    ck(cell_avail_q, 1);
    ck(int_n_q, 0);
    acc(12'h713, 0, 0);
    ck(rdata_q, 8'h18);
    acc(12'h70b, 0, 0);
    ck(rdata_q, 8'h20);
    ck(int_n_q, 1);
    pulse(1, 1);
    ck(cell_avail_q, 1);
    pulse(0, 1);
    ck(cell_avail_q, 0);
    acc(12'h70f, 1, 0);
    pulse(1, 0);
    ck(int_n_q, 1);
    srst = 1'b1;
    tick();
    srst = 1'b0;
    acc(12'h70f, 0, 0);
    ck(rdata_q, 8'h20);
    ce = 1'b0;
    pulse(1, 0);
    ce = 1'b1;
    ck(cell_avail_q, 0);
    ck(int_n_q, 1);
    acc(12'h70b, 0, 0);
    ck(rdata_q, 8'h00);
    summarize;
  end
endmodule
`default_nettype wire
